// ===== src/ppf_pkg.sv
// Purpose: shared addresses, field positions and reset values of the port pin control block
// Assumes: 20-bit cpu address space, byte-wide registers
// Notes: implemented masks mark bits that hold state; other bits read their fixed value
package ppf_pkg;
	// register addresses
	localparam logic [19:0] OFS_PORT0_LATCH = 20'hf_ff00;
	localparam logic [19:0] OFS_PORT4_LATCH = 20'hf_ff04;
	localparam logic [19:0] OFS_PORT12_PINS = 20'hf_ff0c;
	localparam logic [19:0] OFS_PORT0_DIRECTION = 20'hf_ff20;
	localparam logic [19:0] OFS_PORT4_DIRECTION = 20'hf_ff24;
	localparam logic [19:0] OFS_PORT0_PULLUP = 20'hf_0030;
	localparam logic [19:0] OFS_PORT4_PULLUP = 20'hf_0034;
	localparam logic [19:0] OFS_PORT12_PULLUP = 20'hf_003c;
	localparam logic [19:0] OFS_OPEN_DRAIN_SELECT = 20'hf_0050;
	localparam logic [19:0] OFS_ANALOG_INPUT_SELECT = 20'hf_0060;
	localparam logic [19:0] OFS_PIN_REDIRECTION = 20'hf_0077;
	// values after reset
	localparam logic [7:0] RST_PORT_LATCH = 8'h00;
	localparam logic [7:0] RST_DIRECTION = 8'hff;
	localparam logic [7:0] RST_PORT0_PULLUP = 8'h00;
	localparam logic [7:0] RST_PORT4_PULLUP = 8'h01;
	localparam logic [7:0] RST_PORT12_PULLUP = 8'h20;
	localparam logic [7:0] RST_OPEN_DRAIN_SELECT = 8'h00;
	localparam logic [7:0] RST_ANALOG_INPUT_SELECT = 8'hff;
	localparam logic [7:0] RST_PIN_REDIRECTION = 8'h00;
	// implemented bits
	localparam logic [7:0] IMPL_PORT0 = 8'hff;
	localparam logic [7:0] IMPL_PORT4 = 8'h03;
	localparam logic [7:0] IMPL_PORT12_PULLUP = 8'h20;
	localparam logic [7:0] IMPL_OPEN_DRAIN_SELECT = 8'hc3;
	localparam logic [7:0] IMPL_ANALOG_INPUT_SELECT = 8'hfe;
	localparam logic [7:0] IMPL_PIN_REDIRECTION = 8'h1f;
	// field positions
	localparam int IDX_REDIR_BUZZER = 0;
	localparam int IDX_REDIR_TIMER_CH1 = 1;
	localparam int IDX_REDIR_IRQ1 = 2;
	localparam int IDX_REDIR_IRQ2 = 3;
	localparam int IDX_REDIR_IRQ3 = 4;
	localparam int IDX_PORT12_PIN1 = 1;
	localparam int IDX_PORT12_PIN2 = 2;
	localparam int IDX_RESET_PIN = 5;
	localparam int IDX_P0_BUZZER = 2;
	localparam int IDX_P0_TIMER_CH1 = 4;
	localparam int IDX_P0_IRQ1_DEFAULT = 0;
	localparam int IDX_P0_IRQ1_ALT = 3;
	localparam int IDX_P0_IRQ3_DEFAULT = 6;
	localparam int IDX_P4_SHARED = 0;
	localparam int IDX_P4_IRQ2_DEFAULT = 1;
endpackage

// ===== src/ppf_pin_cell.sv
// Purpose: output stage of one port pin: latch and alternate outputs combined, drive type, pull-up
// Assumes: all inputs synchronous to the core clock
// Notes: purely combinational; the oe_n output is low while the pin is driven
`timescale 1ns/10ps
module ppf_pin_cell (
	input wire logic latch,
	input wire logic dir_input,
	input wire logic analog,
	input wire logic open_drain,
	input wire logic pullup_sel,
	input wire logic serial_out,
	input wire logic nonserial_out,
	output logic pin_out,
	output logic pin_oe_n,
	output logic pullup_on
);
	logic combined;

	// serial output gated by the latch, then or-ed with the other functions
	assign combined = (serial_out & latch) | nonserial_out;
	// open drain only pulls low and releases a high; push-pull drives both
	assign pin_out = open_drain ? 1'b0 : combined;
	assign pin_oe_n = ~(~dir_input & ~analog & (~open_drain | ~combined));
	// pull-up only for digital inputs in normal drive mode
	assign pullup_on = pullup_sel & dir_input & ~analog & ~open_drain;
endmodule

// ===== src/ppf_port_ctrl.sv
// Purpose: port 0/4/12 pin control: latches, direction, pull-ups, drive type, analog select, redirection
// Assumes: cpu accesses are single-cycle strobes; pins and peripheral outputs synchronous to core_clk
// Notes: bit writes are done as read, modify one bit, write the byte back
// Notes on behaviour
// - reset pin pull-up bit writable only in general input role; else pull-up forced on
// - open drain select bit: 0 push-pull, 1 n-channel open drain
// - no pull-up ever on a pin selected as open drain
// - open drain and analog select registers take bit and byte writes
// - analog select bits 1 to 7: 0 digital, 1 analog; bit 0 fixed 1
// - analog select register resets to all ones
// - redirection register takes byte writes only, resets to zero
// - redirection bits move irq3, irq2, irq1, timer channel 1, buzzer pins
// - output mode write loads latch and drives it; latch holds value
// - input mode write updates latch, pin stays undriven
// - reset clears the output latch
// - output mode read returns latch, latch unchanged
// - input mode read returns pin level, latch unchanged
// - input mode bit operation works on pin level, result into latch
// - output mode bit operation works on latch, result stored and driven
// - pin output is serial output and latch, or-ed with other outputs
// - missing drive select reads 0, missing serial 1, missing other output 0
// - direction bit 0 output, 1 input; direction resets to all ones
// - pull-up only for digital, input, normal-drive pins
`timescale 1ns/10ps
module ppf_port_ctrl
	import ppf_pkg::*;
#(
	parameter logic [7:0] SERIAL_OUT_PRESENT = 8'ha7,
	parameter logic [7:0] NONSERIAL_OUT_PRESENT = 8'hff,
	parameter int PORT4_BITS = 2
) (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic [19:0] cpu_addr,
	input wire logic cpu_wr,
	input wire logic cpu_bit_wr,
	input wire logic [2:0] cpu_bit_sel,
	input wire logic [7:0] cpu_wdata,
	input wire logic cpu_rd,
	output logic [7:0] cpu_rdata,
	output logic cpu_rvalid,
	input wire logic reset_pin_role_select,
	input wire logic [7:0] p0_pin_in,
	output logic [7:0] p0_pin_out,
	output logic [7:0] p0_pin_oe_n,
	output logic [7:0] p0_pullup,
	input wire logic [1:0] p4_pin_in,
	output logic [1:0] p4_pin_out,
	output logic [1:0] p4_pin_oe_n,
	output logic [1:0] p4_pullup,
	input wire logic p121_pin_in,
	input wire logic p122_pin_in,
	input wire logic reset_shared_pin_in,
	output logic reset_shared_pin_pullup,
	input wire logic [7:0] serial_out_p0,
	input wire logic [7:0] nonserial_out_p0,
	input wire logic timer_ch1_out,
	input wire logic clock_buzzer_out,
	output logic ext_irq_1,
	output logic ext_irq_2,
	output logic ext_irq_3,
	output logic timer_ch1_in
);
	logic [7:0] port0_latch;
	logic [7:0] port4_latch;
	logic [7:0] port0_direction;
	logic [7:0] port4_direction;
	logic [7:0] port0_pullup_sel;
	logic [7:0] port4_pullup_sel;
	logic [7:0] port12_pullup_sel;
	logic [7:0] open_drain_select;
	logic [7:0] analog_input_select;
	logic [7:0] pin_redirection;
	logic [7:0] cur_val;
	logic [7:0] next_val;
	logic [7:0] next_rdata;
	logic [7:0] port0_read;
	logic [7:0] port4_read;
	logic [7:0] port12_read;
	logic [7:0] p0_serial;
	logic [7:0] p0_nonserial;
	logic [1:0] p4_nonserial;
	logic reset_pin_pullup_enable;
	logic any_wr;

	// elaboration check on the port 4 width
	if (PORT4_BITS < 1 || PORT4_BITS > 2) begin : g_bad_port4_bits
		$error("PORT4_BITS must be 1 or 2");
	end

	// replace one bit of a byte
	function automatic logic [7:0] merge_bit(input logic [7:0] cur, input logic [2:0] sel, input logic val);
		logic [7:0] res;
		res = cur;
		res[sel] = val;
		return res;
	endfunction

	// port reads: latch in output mode, pin in input mode, analog inputs read 0
	assign port0_read = (~port0_direction & port0_latch) |
		(port0_direction & ~(analog_input_select & IMPL_ANALOG_INPUT_SELECT) & p0_pin_in);
	assign port4_read = ((~port4_direction & port4_latch) | (port4_direction & {6'b00_0000, p4_pin_in})) &
		IMPL_PORT4;
	assign reset_pin_pullup_enable = reset_pin_role_select | port12_pullup_sel[IDX_RESET_PIN];

	// input-only port 12; reset pin reads 1 while it serves as reset
	always_comb begin
		port12_read = 8'h00;
		port12_read[IDX_PORT12_PIN1] = p121_pin_in;
		port12_read[IDX_PORT12_PIN2] = p122_pin_in;
		port12_read[IDX_RESET_PIN] = reset_pin_role_select | reset_shared_pin_in;
	end

	// current value of the addressed register, used for reads and bit writes
	always_comb begin
		case (cpu_addr)
			OFS_PORT0_LATCH: cur_val = port0_read;
			OFS_PORT4_LATCH: cur_val = port4_read;
			OFS_PORT12_PINS: cur_val = port12_read;
			OFS_PORT0_DIRECTION: cur_val = port0_direction;
			OFS_PORT4_DIRECTION: cur_val = port4_direction;
			OFS_PORT0_PULLUP: cur_val = port0_pullup_sel;
			OFS_PORT4_PULLUP: cur_val = port4_pullup_sel;
			OFS_PORT12_PULLUP: cur_val = {2'b00, reset_pin_pullup_enable, 5'b0_0000};
			OFS_OPEN_DRAIN_SELECT: cur_val = open_drain_select;
			OFS_ANALOG_INPUT_SELECT: cur_val = analog_input_select;
			OFS_PIN_REDIRECTION: cur_val = pin_redirection;
			default: cur_val = 8'h00;
		endcase
	end

	// byte to store: whole byte, or current value with one bit replaced
	assign next_val = cpu_bit_wr ? merge_bit(cur_val, cpu_bit_sel, cpu_wdata[0]) : cpu_wdata;
	assign any_wr = cpu_wr | cpu_bit_wr;
	assign next_rdata = cur_val;

	// read data is registered, valid one cycle after the strobe
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			cpu_rdata <= 8'h00;
			cpu_rvalid <= 1'b0;
		end else begin
			cpu_rvalid <= cpu_rd;
			if (cpu_rd) begin
				cpu_rdata <= next_rdata;
			end
		end
	end

	// output latches, written in either direction mode
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			port0_latch <= RST_PORT_LATCH;
			port4_latch <= RST_PORT_LATCH;
		end else if (any_wr) begin
			if (cpu_addr == OFS_PORT0_LATCH) begin
				port0_latch <= next_val;
			end
			if (cpu_addr == OFS_PORT4_LATCH) begin
				port4_latch <= next_val & IMPL_PORT4;
			end
		end
	end

	// direction registers
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			port0_direction <= RST_DIRECTION;
			port4_direction <= RST_DIRECTION;
		end else if (any_wr) begin
			if (cpu_addr == OFS_PORT0_DIRECTION) begin
				port0_direction <= next_val;
			end
			if (cpu_addr == OFS_PORT4_DIRECTION) begin
				port4_direction <= (next_val & IMPL_PORT4) | (RST_DIRECTION & ~IMPL_PORT4);
			end
		end
	end

	// pull-up selects; reset pin bit frozen while the pin serves as reset
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			port0_pullup_sel <= RST_PORT0_PULLUP;
			port4_pullup_sel <= RST_PORT4_PULLUP;
			port12_pullup_sel <= RST_PORT12_PULLUP;
		end else if (any_wr) begin
			if (cpu_addr == OFS_PORT0_PULLUP) begin
				port0_pullup_sel <= next_val;
			end
			if (cpu_addr == OFS_PORT4_PULLUP) begin
				port4_pullup_sel <= next_val & IMPL_PORT4;
			end
			if (cpu_addr == OFS_PORT12_PULLUP && !reset_pin_role_select) begin
				port12_pullup_sel <= next_val & IMPL_PORT12_PULLUP;
			end
		end
	end

	// drive type and analog select, bit and byte writes alike
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			open_drain_select <= RST_OPEN_DRAIN_SELECT;
			analog_input_select <= RST_ANALOG_INPUT_SELECT;
		end else if (any_wr) begin
			if (cpu_addr == OFS_OPEN_DRAIN_SELECT) begin
				open_drain_select <= next_val & IMPL_OPEN_DRAIN_SELECT;
			end
			if (cpu_addr == OFS_ANALOG_INPUT_SELECT) begin
				analog_input_select <= (next_val & IMPL_ANALOG_INPUT_SELECT) |
					(RST_ANALOG_INPUT_SELECT & ~IMPL_ANALOG_INPUT_SELECT);
			end
		end
	end

	// redirection takes byte writes only; bit writes are dropped
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			pin_redirection <= RST_PIN_REDIRECTION;
		end else if (cpu_wr && !cpu_bit_wr && cpu_addr == OFS_PIN_REDIRECTION) begin
			pin_redirection <= cpu_wdata & IMPL_PIN_REDIRECTION;
		end
	end

	// alternate output sources per pin, absent ones parked at their idle level
	always_comb begin
		p0_serial = serial_out_p0 | ~SERIAL_OUT_PRESENT;
		p0_nonserial = nonserial_out_p0 & NONSERIAL_OUT_PRESENT;
		p0_nonserial[IDX_P0_BUZZER] = p0_nonserial[IDX_P0_BUZZER] |
			(clock_buzzer_out & ~pin_redirection[IDX_REDIR_BUZZER]);
		p0_nonserial[IDX_P0_TIMER_CH1] = p0_nonserial[IDX_P0_TIMER_CH1] |
			(timer_ch1_out & ~pin_redirection[IDX_REDIR_TIMER_CH1]);
		p4_nonserial = 2'b00;
		p4_nonserial[IDX_P4_SHARED] = (clock_buzzer_out & pin_redirection[IDX_REDIR_BUZZER]) |
			(timer_ch1_out & pin_redirection[IDX_REDIR_TIMER_CH1]);
	end

	// redirected inputs
	assign ext_irq_1 = pin_redirection[IDX_REDIR_IRQ1] ? p0_pin_in[IDX_P0_IRQ1_ALT] :
		p0_pin_in[IDX_P0_IRQ1_DEFAULT];
	assign ext_irq_2 = pin_redirection[IDX_REDIR_IRQ2] ? p122_pin_in : p4_pin_in[IDX_P4_IRQ2_DEFAULT];
	assign ext_irq_3 = pin_redirection[IDX_REDIR_IRQ3] ? p121_pin_in : p0_pin_in[IDX_P0_IRQ3_DEFAULT];
	assign timer_ch1_in = pin_redirection[IDX_REDIR_TIMER_CH1] ? p4_pin_in[IDX_P4_SHARED] :
		p0_pin_in[IDX_P0_TIMER_CH1];
	assign reset_shared_pin_pullup = reset_pin_pullup_enable;

	// one output stage per pin
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_p0
			ppf_pin_cell u_cell (
				.latch(port0_latch[gi]),
				.dir_input(port0_direction[gi]),
				.analog(analog_input_select[gi] & (gi != 0)),
				.open_drain(open_drain_select[gi]),
				.pullup_sel(port0_pullup_sel[gi]),
				.serial_out(p0_serial[gi]),
				.nonserial_out(p0_nonserial[gi]),
				.pin_out(p0_pin_out[gi]),
				.pin_oe_n(p0_pin_oe_n[gi]),
				.pullup_on(p0_pullup[gi])
			);
		end
		for (gi = 0; gi < 2; gi++) begin : g_p4
			ppf_pin_cell u_cell (
				.latch(port4_latch[gi] & (gi < PORT4_BITS)),
				.dir_input(port4_direction[gi] | (gi >= PORT4_BITS)),
				.analog(1'b0),
				.open_drain(1'b0),
				.pullup_sel(port4_pullup_sel[gi]),
				.serial_out(1'b1),
				.nonserial_out(p4_nonserial[gi]),
				.pin_out(p4_pin_out[gi]),
				.pin_oe_n(p4_pin_oe_n[gi]),
				.pullup_on(p4_pullup[gi])
			);
		end
	endgenerate

	// checks on the behaviour above
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rstn);

	sequence s_p0_bit_wr_all_inputs;
		cpu_bit_wr && !cpu_wr && cpu_addr == OFS_PORT0_LATCH && port0_direction == 8'hff &&
			analog_input_select == 8'h01;
	endsequence

	sequence s_p0_read_req;
		cpu_rd && cpu_addr == OFS_PORT0_LATCH;
	endsequence

	reset_values_a: assert property (disable iff (1'b0) !rstn |=> analog_input_select == RST_ANALOG_INPUT_SELECT &&
		pin_redirection == RST_PIN_REDIRECTION && port0_latch == RST_PORT_LATCH &&
		port0_direction == RST_DIRECTION) else $error("reset values wrong");
	od_no_pullup_a: assert property ((p0_pullup & open_drain_select) == 8'h00)
		else $error("pull-up on open drain pin");
	analog_bit0_a: assert property (analog_input_select[0] == 1'b1)
		else $error("analog select bit 0 not fixed");
	redir_bitwr_a: assert property (cpu_bit_wr && !cpu_wr && cpu_addr == OFS_PIN_REDIRECTION |=>
		$stable(pin_redirection)) else $error("redirection changed by bit write");
	input_read_a: assert property (s_p0_read_req ##0 port0_direction == 8'hff |=>
		cpu_rvalid && cpu_rdata == ($past(p0_pin_in) & ~($past(analog_input_select) & IMPL_ANALOG_INPUT_SELECT)))
		else $error("input read not pin level");
	output_read_a: assert property (s_p0_read_req ##0 port0_direction == 8'h00 && !any_wr |=>
		cpu_rdata == port0_latch) else $error("output read not latch");
	latch_hold_a: assert property (!(any_wr && cpu_addr == OFS_PORT0_LATCH) |=> $stable(port0_latch))
		else $error("latch changed without write");
	input_undriven_a: assert property ((p0_pin_oe_n & port0_direction) == port0_direction)
		else $error("input pin driven");
	rmw_input_a: assert property (s_p0_bit_wr_all_inputs |=>
		port0_latch == merge_bit($past(p0_pin_in), $past(cpu_bit_sel), $past(cpu_wdata[0])))
		else $error("bit write in input mode wrong");
	rmw_output_a: assert property (cpu_bit_wr && !cpu_wr && cpu_addr == OFS_PORT0_LATCH &&
		port0_direction == 8'h00 |=> port0_latch == merge_bit($past(port0_latch), $past(cpu_bit_sel),
		$past(cpu_wdata[0]))) else $error("bit write in output mode wrong");
	reset_pullup_a: assert property (reset_pin_role_select |-> reset_shared_pin_pullup)
		else $error("reset pin pull-up off");
	od_drive_a: assert property ((~p0_pin_oe_n & open_drain_select & p0_pin_out) == 8'h00)
		else $error("open drain pin driven high");
	irq1_route_a: assert property (pin_redirection[IDX_REDIR_IRQ1] |-> ext_irq_1 == p0_pin_in[IDX_P0_IRQ1_ALT])
		else $error("irq1 redirection wrong");
	pushpull_a: assert property (port0_direction[3] == 1'b0 && analog_input_select[3] == 1'b0 &&
		open_drain_select[3] == 1'b0 |-> !p0_pin_oe_n[3] &&
		p0_pin_out[3] == ((p0_serial[3] & port0_latch[3]) | p0_nonserial[3]))
		else $error("push-pull output wrong");
	// timer, irq3 and buzzer routes, reset pin pull-up freeze and analog pins left undriven
	timer_route_a: assert property (pin_redirection[IDX_REDIR_TIMER_CH1] |-> timer_ch1_in == p4_pin_in[IDX_P4_SHARED])
		else $error("timer input redirection wrong");
	irq3_route_a: assert property (!pin_redirection[IDX_REDIR_IRQ3] |-> ext_irq_3 == p0_pin_in[IDX_P0_IRQ3_DEFAULT])
		else $error("irq3 redirection wrong");
	buzzer_route_a: assert property (pin_redirection[IDX_REDIR_BUZZER] && !pin_redirection[IDX_REDIR_TIMER_CH1] |->
		p4_nonserial[IDX_P4_SHARED] == clock_buzzer_out) else $error("buzzer redirection wrong");
	pu12_frozen_a: assert property (reset_pin_role_select && any_wr && cpu_addr == OFS_PORT12_PULLUP |=>
		$stable(port12_pullup_sel)) else $error("reset pin pull-up bit written as reset");
	analog_undriven_a: assert property ((p0_pin_oe_n | ~(analog_input_select & IMPL_ANALOG_INPUT_SELECT)) == 8'hff)
		else $error("analog pin driven");
endmodule

// ===== dv/ppf_board_model.sv
// Purpose: board side of the port 0 and port 4 pins
// Assumes: the board source is a plain level for each pin
// Notes: a released pin without pull-up shows the board level, never the last driven value
`timescale 1ns/10ps
module ppf_board_model (
	input wire logic [9:0] drv,
	input wire logic [9:0] oe_n,
	input wire logic [9:0] pull,
	input wire logic [9:0] board,
	output logic [9:0] lvl
);
	// pin level from drive, else pull-up, else board source
	always_comb begin
		for (int i = 0; i < 10; i++) begin
			lvl[i] = !oe_n[i] ? drv[i] : (pull[i] ? 1'b1 : board[i]);
		end
	end
endmodule

// ===== dv/port_pin_function_control_bench.sv
// Purpose: self-checking bench for the port pin control block
// Assumes: 40 MHz core clock, synchronous active-low reset
// Notes: inputs move on the falling edge; an integer model predicts pins and reads
`timescale 1ns/10ps
module port_pin_function_control_bench
	import ppf_pkg::*;
;
`define PPF_CHK(n, e, a) begin checks++; if ((a) !== 8'(e)) begin miscompares++; \
	$display("CHECK FAILED %s exp %h got %h", n, 8'(e), a); end end
	logic core_clk = 0;
	logic rstn = 0;
	logic [19:0] cpu_addr = '0;
	logic cpu_wr = 0, cpu_bit_wr = 0, cpu_rd = 0, role = 1, cpu_rvalid, rs_pu, irq1, irq2, irq3, tin;
	logic [2:0] cpu_bit_sel = '0;
	logic [7:0] cpu_wdata = '0, ext0 = '0, ser = 8'hff, non = '0, cpu_rdata, p0_out, p0_oe_n, p0_pu;
	logic [1:0] ext4 = '0, p4_out, p4_oe_n, p4_pu;
	logic p121 = 0, p122 = 0, rsp = 1, tmr = 0, buz = 0;
	wire logic [9:0] lvl;
	int miscompares = 0, checks = 0;
	int lat0 = 0, lat4 = 0, dir0 = 8'hff, dir4 = 3, pu0 = 0, pu4 = 1, pu12 = 1, od = 0, an = 8'hff, pr = 0;
	int e_oe0, e_out0, e_pu0, lvl0, e_oe4, e_out4, e_pu4, lvl4;
	logic [19:0] adr [12] = '{OFS_PORT0_LATCH, OFS_PORT4_LATCH, OFS_PORT12_PINS, OFS_PORT0_DIRECTION,
		OFS_PORT4_DIRECTION, OFS_PORT0_PULLUP, OFS_PORT4_PULLUP, OFS_PORT12_PULLUP, OFS_OPEN_DRAIN_SELECT,
		OFS_ANALOG_INPUT_SELECT, OFS_PIN_REDIRECTION, 20'hf_0051};

	// clock
	always #12.5 core_clk = ~core_clk;

	// design and board
	ppf_port_ctrl #(.SERIAL_OUT_PRESENT(8'ha7), .NONSERIAL_OUT_PRESENT(8'hff), .PORT4_BITS(2)) DUT (
		.core_clk(core_clk), .rstn(rstn), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr), .cpu_bit_wr(cpu_bit_wr),
		.cpu_bit_sel(cpu_bit_sel), .cpu_wdata(cpu_wdata), .cpu_rd(cpu_rd), .cpu_rdata(cpu_rdata),
		.cpu_rvalid(cpu_rvalid), .reset_pin_role_select(role), .p0_pin_in(lvl[7:0]), .p0_pin_out(p0_out),
		.p0_pin_oe_n(p0_oe_n), .p0_pullup(p0_pu), .p4_pin_in(lvl[9:8]), .p4_pin_out(p4_out),
		.p4_pin_oe_n(p4_oe_n), .p4_pullup(p4_pu), .p121_pin_in(p121), .p122_pin_in(p122),
		.reset_shared_pin_in(rsp), .reset_shared_pin_pullup(rs_pu), .serial_out_p0(ser),
		.nonserial_out_p0(non), .timer_ch1_out(tmr), .clock_buzzer_out(buz), .ext_irq_1(irq1),
		.ext_irq_2(irq2), .ext_irq_3(irq3), .timer_ch1_in(tin));
	ppf_board_model u_board (.drv({p4_out, p0_out}), .oe_n({p4_oe_n, p0_oe_n}), .pull({p4_pu, p0_pu}),
		.board({ext4, ext0}), .lvl(lvl));

	// expected pin drive, pull-ups and levels from the model state
	task automatic calc();
		int ae, c0, c4;
		ae = an & 8'hfe;
		c0 = ((ser | ~8'ha7) & lat0) | non | ((buz & !pr[0]) << 2) | ((tmr & !pr[1]) << 4);
		e_oe0 = (ae | dir0 | (od & c0)) & 8'hff;
		e_out0 = c0 & ~od & ~e_oe0 & 8'hff;
		e_pu0 = pu0 & dir0 & ~ae & ~od & 8'hff;
		lvl0 = (e_out0 & ~e_oe0) | (e_oe0 & (e_pu0 | ext0));
		c4 = lat4 | (buz & pr[0]) | (tmr & pr[1]);
		e_oe4 = dir4 & 3;
		e_out4 = c4 & ~dir4 & 3;
		e_pu4 = pu4 & dir4 & 3;
		lvl4 = (e_out4 & ~e_oe4) | (e_oe4 & (e_pu4 | ext4));
	endtask

	// expected read value of each address
	function automatic int rdx(logic [19:0] a);
		case (a)
			OFS_PORT0_LATCH: return (dir0 & ~(an & 8'hfe) & lvl0) | (~dir0 & lat0 & 8'hff);
			OFS_PORT4_LATCH: return ((dir4 & lvl4) | (~dir4 & lat4)) & 3;
			OFS_PORT12_PINS: return (p121 << 1) | (p122 << 2) | ((role | rsp) << 5);
			OFS_PORT0_DIRECTION: return dir0;
			OFS_PORT4_DIRECTION: return dir4 | 8'hfc;
			OFS_PORT0_PULLUP: return pu0;
			OFS_PORT4_PULLUP: return pu4;
			OFS_PORT12_PULLUP: return (role | pu12) << 5;
			OFS_OPEN_DRAIN_SELECT: return od;
			OFS_ANALOG_INPUT_SELECT: return an | 1;
			OFS_PIN_REDIRECTION: return pr;
			default: return 0;
		endcase
	endfunction

	// software side keeps unused bits, analog direction and redirection pairs legal
	function automatic int fix(logic [19:0] a, int d);
		case (a)
			OFS_PORT0_DIRECTION: return (d | (an & 8'hfe)) & 8'hff;
			OFS_PORT4_DIRECTION: return (d | 8'hfc) & 8'hff;
			OFS_ANALOG_INPUT_SELECT: return (d & dir0) | 1;
			OFS_OPEN_DRAIN_SELECT: return d & 8'hc3;
			OFS_PIN_REDIRECTION: return (d[0] ? d & 8'hfd : d) & 8'h1f;
			OFS_PORT4_LATCH, OFS_PORT4_PULLUP: return d & 3;
			OFS_PORT12_PULLUP: return d & 8'h20;
			default: return d & 8'hff;
		endcase
	endfunction

	// model register update
	task automatic mw(logic [19:0] a, int d);
		case (a)
			OFS_PORT0_LATCH: lat0 = d;
			OFS_PORT4_LATCH: lat4 = d;
			OFS_PORT0_DIRECTION: dir0 = d;
			OFS_PORT4_DIRECTION: dir4 = d & 3;
			OFS_PORT0_PULLUP: pu0 = d;
			OFS_PORT4_PULLUP: pu4 = d;
			OFS_PORT12_PULLUP: if (!role) pu12 = d[5];
			OFS_OPEN_DRAIN_SELECT: od = d;
			OFS_ANALOG_INPUT_SELECT: an = d;
			OFS_PIN_REDIRECTION: pr = d;
			default: ;
		endcase
	endtask

	// pins and routed inputs against the model
	task automatic chk();
		calc();
		`PPF_CHK("p0 oe_n", e_oe0, p0_oe_n)
		`PPF_CHK("p0 out", e_out0, p0_out & ~8'(e_oe0))
		`PPF_CHK("p0 pullup", e_pu0, p0_pu)
		`PPF_CHK("p4 oe_n", e_oe4, p4_oe_n)
		`PPF_CHK("p4 out", e_out4, p4_out & ~2'(e_oe4))
		`PPF_CHK("p4 pullup", e_pu4, p4_pu)
		`PPF_CHK("irq1", pr[2] ? lvl0[3] : lvl0[0], irq1)
		`PPF_CHK("irq2", pr[3] ? p122 : lvl4[1], irq2)
		`PPF_CHK("irq3", pr[4] ? p121 : lvl0[6], irq3)
		`PPF_CHK("timer in", pr[1] ? lvl4[0] : lvl0[4], tin)
		`PPF_CHK("reset pin pullup", role | pu12, rs_pu)
	endtask

	// one bus operation: k 0 byte write, 1 bit write, 2 read
	task automatic op(int k, logic [19:0] a, int d, int b);
		int e, nb;
		@(negedge core_clk);
		calc();
		e = rdx(a);
		nb = fix(a, k == 1 ? (e & ~(1 << b)) | ((d & 1) << b) : d);
		cpu_addr = a;
		cpu_bit_sel = 3'(b);
		cpu_wdata = k == 1 ? 8'(nb >> b & 1) : 8'(nb);
		cpu_wr = k == 0;
		cpu_bit_wr = k == 1;
		cpu_rd = k == 2;
		@(negedge core_clk);
		cpu_wr = 0;
		cpu_bit_wr = 0;
		cpu_rd = 0;
		if (k == 0 || (k == 1 && a != OFS_PIN_REDIRECTION)) mw(a, nb);
		if (k == 2) begin
			for (int i = 0; i < 3 && cpu_rvalid !== 1'b1; i++) @(negedge core_clk);
			`PPF_CHK("rvalid", 1, cpu_rvalid)
			`PPF_CHK("rdata", e, cpu_rdata)
		end
		chk();
	endtask

	// verdict and end of run
	task automatic test_done();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// watchdog far beyond the roughly 900 cycles the tests need
	initial begin
		#(25 * 20000);
		miscompares++;
		test_done();
	end

	// test sequence; serial outputs parked high, other port 0 outputs low until the random test; timer and buzzer random from the redirection test
	initial begin
		void'($urandom(4952));
		repeat (2) @(negedge core_clk);
		rstn = 1;
		chk();
		op(2, OFS_OPEN_DRAIN_SELECT, 0, 0);
		`PPF_CHK("reset open drain", 8'h00, cpu_rdata)
		op(2, OFS_ANALOG_INPUT_SELECT, 0, 0);
		`PPF_CHK("reset analog", 8'hff, cpu_rdata)
		op(2, OFS_PIN_REDIRECTION, 0, 0);
		`PPF_CHK("reset redirection", 8'h00, cpu_rdata)
		$display("test reset_values done");
		ext0 = 8'hff;
		op(0, OFS_ANALOG_INPUT_SELECT, 0, 0);
		op(0, OFS_PORT0_DIRECTION, 0, 0);
		op(2, OFS_PORT0_LATCH, 0, 0);
		`PPF_CHK("latch after reset", 8'h00, cpu_rdata)
		op(0, OFS_PORT0_DIRECTION, 8'hff, 0);
		op(1, OFS_PORT0_LATCH, 0, 5);
		op(0, OFS_PORT0_DIRECTION, 8'hfe, 0);
		op(1, OFS_PORT0_LATCH, 1, 0);
		op(0, OFS_PORT0_DIRECTION, 0, 0);
		op(2, OFS_PORT0_LATCH, 0, 0);
		`PPF_CHK("input mode bit op", 8'hff, cpu_rdata)
		op(1, OFS_PORT0_LATCH, 0, 3);
		op(0, OFS_OPEN_DRAIN_SELECT, 8'hc3, 0);
		op(1, OFS_OPEN_DRAIN_SELECT, 0, 7);
		$display("test port_modes done");
		for (int v = 0; v < 32; v++) begin
			ext0 = 8'($urandom);
			ext4 = 2'($urandom);
			{p121, p122, tmr, buz} = 4'($urandom);
			op(0, OFS_PIN_REDIRECTION, v, 0);
		end
		op(1, OFS_PIN_REDIRECTION, 0, 4);
		op(2, OFS_PIN_REDIRECTION, 0, 0);
		$display("test redirection done");
		role = 0;
		op(0, OFS_PORT12_PULLUP, 0, 0);
		role = 1;
		op(2, OFS_PORT12_PULLUP, 0, 0);
		op(0, OFS_PORT12_PULLUP, 8'h20, 0);
		role = 0;
		op(2, OFS_PORT12_PULLUP, 0, 0);
		$display("test reset_pin_pullup done");
		for (int i = 0; i < 400; i++) begin
			ext0 = 8'($urandom);
			ext4 = 2'($urandom);
			ser = 8'($urandom);
			non = 8'($urandom);
			{p121, p122, tmr, buz, rsp} = 5'($urandom);
			if (i % 40 == 0) role = 1'($urandom);
			op($urandom % 3, adr[$urandom % 12], $urandom, $urandom % 8);
		end
		$display("test random_access done");
		test_done();
	end
endmodule
